/* core/lcd_pkg.sv */
/*
  Package for the dot-matrix panel drive block: sizes, command fields,
  timing figures and the frame-divider encoding.
  Assumes the core issues one-cycle strobes for pointer, data and commands.
*/
package lcd_pkg;

  // ----------------------------------------
  // Panel geometry
  // ----------------------------------------
  localparam int SEG_COUNT       = 40;
  localparam int COM_COUNT       = 16;
  localparam int RAM_WORDS       = 160;
  localparam int PTR_W           = 8;
  localparam int NIB_W           = 4;
  localparam int RAM_IDX_W       = 8;

  // ----------------------------------------
  // Address map of the display RAM
  // ----------------------------------------
  localparam logic [7:0] BANK0_LAST = 8'h4f;
  localparam logic [7:0] BANK1_BASE = 8'h80;
  localparam logic [7:0] BANK1_LAST = 8'hcf;
  localparam logic [7:0] BANK1_OFS  = 8'h50;
  localparam logic [7:0] DC_LO_ADDR = 8'h40;
  localparam logic [7:0] DC_HI_ADDR = 8'h41;
  localparam int DC_SEG_BASE     = 32;
  localparam int DC_GRP_W        = 4;

  // ----------------------------------------
  // Contrast register
  // ----------------------------------------
  localparam int CONTRAST_W      = 3;
  localparam logic [2:0] CONTRAST_RESET = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_HZ        = 25000000;
  localparam int SUB_CLOCK_HZ    = 32768;
  // Sub-clock tick spacing, nearest whole cycle (true rate is not integral)
  localparam int SUB_TICK_CYCLES = (CLOCK_HZ + SUB_CLOCK_HZ / 2) / SUB_CLOCK_HZ;
  localparam int SUB_TICK_W      = 10;
  // Sub-clock ticks per frame step, less one, for each divider setting
  localparam int FDIV16_LAST     = 15;
  localparam int FDIV32_LAST     = 31;
  localparam int FDIV64_LAST     = 63;
  localparam int FDIV128_LAST    = 127;

  // Frame divider select: sub_clock divided by 16/32/64/128
  typedef enum logic [1:0] {
    LCD_DIV16  = 2'h0,
    LCD_DIV32  = 2'h1,
    LCD_DIV64  = 2'h2,
    LCD_DIV128 = 2'h3
  } lcd_div_t;

  // Core access strobes travel together
  typedef struct packed {
    logic       ptr_lo_we;
    logic       ptr_hi_we;
    logic       ram_we;
    logic       ram_re;
    logic       contrast_we;
    logic       on_cmd;
    logic       off_cmd;
    logic [3:0] wdata;
  } lcd_core_req_t;

endpackage

/* core/lcd_divider.sv */
/*
  Cycle divider: emits a one-cycle enable every DIV cycles of clock.
  Assumes clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module lcd_divider #(
  parameter int DIV = 16,
  parameter int W   = 8
) (
  input  wire logic clock,    // System clock
  input  wire logic sys_rst,  // Sync reset
  input  wire logic enable,   // Count enable
  output logic      tick      // One-cycle pulse
);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
    end else if (enable) begin
      count <= (count == LAST) ? '0 : count + 1'b1;
    end
  end

  assign tick = enable && (count == LAST);
endmodule
`default_nettype wire

/* core/lcd_drive.sv */
/*
  Panel drive block: display RAM, write-only pointer, contrast code,
  frame timing from the sub-clock and common/segment scan.
  Assumes core strobes are single-cycle and synchronous to clock; analog
  level generation turns the dot states and contrast code into voltages.
*/
// How it works
// RULE1 - Forty segment and sixteen common outputs address 640 dots.
// RULE2 - Duty is eighth or sixteenth, fixed by a build parameter, fifth bias.
// RULE3 - Frame clock is sub-clock divided by 16, 32, 64 or 128.
// RULE4 - Divide-by-128 only with eighth duty, divide-by-16 only sixteenth duty.
// RULE5 - 160 four-bit display RAM words feed the forty segments.
// RULE6 - RAM is scanned to segments continuously without processor help.
// RULE7 - RAM bit one lights the dot, zero leaves it dark.
// RULE8 - On command enables drive, off command disables, runs in hold.
// RULE9 - Reset leaves the display off until firmware issues on.
// RULE10 - RAM lives at 00h-4Fh and 80h-CFh, reachable only by pointer.
// RULE11 - Pointer is 8-bit write-only, nibbles loaded separately, unreadable.
// RULE12 - Indirect write and read move a nibble at the pointer.
// RULE13 - Contrast low three bits pick one of eight taps; bit 3 unused.
// RULE14 - Segments 32-39 can be open-drain DC outputs, two independent options.
// RULE15 - Address 40 drives segments 32-35, address 41 segments 36-39.
// RULE16 - In DC mode an indirect write goes straight onto the pins.
// RULE17 - Commons fire one at a time cyclically, matching bits on segments.
`timescale 1ns/1ns
`default_nettype none
module lcd_drive
  import lcd_pkg::*;
#(
  parameter bit DUTY16   = 1'b1,  // 1: sixteenth duty, 0: eighth duty
  parameter bit DC_LO_EN = 1'b0,  // Segments 32-35 as DC outputs
  parameter bit DC_HI_EN = 1'b0   // Segments 36-39 as DC outputs
) (
  input  wire logic                  clock,        // 25 MHz system clock
  input  wire logic                  sys_rst,      // Sync reset, active high
  input  wire lcd_core_req_t         core_req,     // Core access strobes and data
  input  wire lcd_div_t              frame_div,    // Frame divider select
  input  wire logic                  hold_mode,    // Core in hold low-power mode
  output logic [NIB_W-1:0]           ram_rdata,    // Indirect read data
  output logic                       ram_rvalid,   // Read data valid pulse
  output logic                       display_enabled, // Drive is on
  output logic [CONTRAST_W-1:0]      contrast_tap, // Resistor tap code
  output logic                       frame_alternating_clock, // Polarity toggle
  output logic [COM_COUNT-1:0]       com_select,   // Active common, one-hot
  output logic [SEG_COUNT-1:0]       seg_dot_on,   // Dot state per segment
  output logic [SEG_COUNT-1:0]       seg_dc_mode,  // Segment used as DC output
  output logic [SEG_COUNT-1:0]       seg_dc_oe     // Open-drain pull-low enable
);

  // ----------------------------------------
  // Local figures
  // ----------------------------------------
  localparam int ACTIVE_COMS  = DUTY16 ? COM_COUNT : COM_COUNT / 2;
  localparam int COM_IDX_W    = 4;
  localparam logic [COM_IDX_W-1:0] COM_LAST = COM_IDX_W'(ACTIVE_COMS - 1);
  // Each segment owns four RAM words, one per group of four commons: 40 seg x 16 com
  // = 640 bits = 160 nibbles; word = seg*4 + com/4 in bank-linear order.
  localparam int WORDS_PER_SEG = COM_COUNT / NIB_W;
  localparam int NIB_SEL_W    = $clog2(NIB_W);
  localparam int FDIV_W       = 7;

  // ----------------------------------------
  // Sub-clock tick
  // ----------------------------------------
  logic sub_tick;

  lcd_divider #(
    .DIV (SUB_TICK_CYCLES),
    .W   (SUB_TICK_W)
  ) u_sub_div (
    .clock   (clock),
    .sys_rst (sys_rst),
    .enable  (1'b1),
    .tick    (sub_tick)
  );

  // ----------------------------------------
  // Pointer, contrast, display enable
  // ----------------------------------------
  logic [PTR_W-1:0] lcd_ram_pointer;
  logic [NIB_W-1:0] contrast_control;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lcd_ram_pointer <= '0;
    end else begin
      if (core_req.ptr_lo_we) begin
        lcd_ram_pointer[NIB_W-1:0] <= core_req.wdata; // RULE11
      end
      if (core_req.ptr_hi_we) begin
        lcd_ram_pointer[PTR_W-1:NIB_W] <= core_req.wdata; // RULE11
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      contrast_control <= {1'b0, CONTRAST_RESET};
    end else if (core_req.contrast_we) begin
      contrast_control <= {1'b0, core_req.wdata[CONTRAST_W-1:0]}; // RULE13
    end
  end

  assign contrast_tap = contrast_control[CONTRAST_W-1:0]; // RULE13

  // Hold mode does not touch this flag, so drive keeps running
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      display_enabled <= 1'b0; // RULE9
    end else if (core_req.on_cmd) begin
      display_enabled <= 1'b1; // RULE8
    end else if (core_req.off_cmd) begin
      display_enabled <= 1'b0; // RULE8
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic                 ptr_hit;
  logic [RAM_IDX_W-1:0] ptr_index;

  always_comb begin
    ptr_hit   = 1'b0;
    ptr_index = '0;
    if (lcd_ram_pointer <= BANK0_LAST) begin
      ptr_hit   = 1'b1; // RULE10
      ptr_index = lcd_ram_pointer;
    end else if (lcd_ram_pointer >= BANK1_BASE && lcd_ram_pointer <= BANK1_LAST) begin
      ptr_hit   = 1'b1; // RULE10
      ptr_index = lcd_ram_pointer - BANK1_BASE + BANK1_OFS;
    end
  end

  // ----------------------------------------
  // Display RAM
  // ----------------------------------------
  logic [NIB_W-1:0] display_ram [RAM_WORDS]; // RULE5

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        display_ram[i] <= '0;
      end
    end else if (core_req.ram_we && ptr_hit) begin
      display_ram[ptr_index] <= core_req.wdata; // RULE12
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [NIB_W-1:0] rd_word;

  // Unmapped pointer reads return zero; pointer itself is never readable
  always_comb begin
    rd_word = '0;
    if (ptr_hit) begin
      rd_word = display_ram[ptr_index]; // RULE12
    end
  end

  // Registered so the core samples a settled nibble one cycle after its strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ram_rdata  <= '0;
      ram_rvalid <= 1'b0;
    end else begin
      ram_rvalid <= core_req.ram_re;
      if (core_req.ram_re) begin
        ram_rdata <= rd_word; // RULE12 RULE11
      end
    end
  end

  // ----------------------------------------
  // Frame clock
  // ----------------------------------------
  lcd_div_t        eff_div;
  logic [FDIV_W-1:0] fdiv_count;
  logic [FDIV_W-1:0] next_fdiv_count;
  logic [FDIV_W-1:0] fdiv_last;
  logic              frame_step;

  // Illegal pairings fall back to the nearest allowed divider
  // so a bad select still yields a legal frame rate, never a stall
  always_comb begin
    eff_div = frame_div;
    if (!DUTY16 && frame_div == LCD_DIV16) begin
      eff_div = LCD_DIV32; // RULE4
    end else if (DUTY16 && frame_div == LCD_DIV128) begin
      eff_div = LCD_DIV64; // RULE4
    end
  end

  always_comb begin
    case (eff_div)
      LCD_DIV16:  fdiv_last = FDIV_W'(FDIV16_LAST); // RULE3
      LCD_DIV32:  fdiv_last = FDIV_W'(FDIV32_LAST);
      LCD_DIV64:  fdiv_last = FDIV_W'(FDIV64_LAST);
      LCD_DIV128: fdiv_last = FDIV_W'(FDIV128_LAST);
      default:    fdiv_last = FDIV_W'(FDIV32_LAST);
    endcase
  end

  // Half period of the frame clock is one divider interval
  assign frame_step = sub_tick && (fdiv_count >= fdiv_last);

  // Count sub-clock ticks; wrap on the step so the next interval starts clean
  always_comb begin
    next_fdiv_count = fdiv_count;
    if (sub_tick) begin
      next_fdiv_count = frame_step ? '0 : fdiv_count + 1'b1; // RULE3
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fdiv_count <= '0;
    end else begin
      fdiv_count <= next_fdiv_count;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_alternating_clock <= 1'b0;
    end else if (frame_step && display_enabled) begin
      frame_alternating_clock <= ~frame_alternating_clock; // RULE3
    end
  end

  // ----------------------------------------
  // Common scan
  // ----------------------------------------
  logic [COM_IDX_W-1:0] com_index;
  logic [COM_IDX_W-1:0] next_com_index;
  logic [COM_COUNT-1:0] next_com_select;

  // One common slot per frame-clock step; wraps at the duty count
  always_comb begin
    next_com_index = com_index;
    if (!display_enabled) begin
      next_com_index = '0;
    end else if (frame_step) begin
      next_com_index = (com_index == COM_LAST) ? '0 : com_index + 1'b1; // RULE17 RULE2
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      com_index <= '0;
    end else begin
      com_index <= next_com_index;
    end
  end

  // Dark while off, so the glass sees no stray common pulse
  always_comb begin
    next_com_select = '0;
    if (display_enabled) begin
      next_com_select[com_index] = 1'b1; // RULE17 RULE1
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      com_select <= '0;
    end else begin
      com_select <= next_com_select;
    end
  end

  // ----------------------------------------
  // Segment fetch and DC outputs
  // ----------------------------------------
  logic [SEG_COUNT-1:0] next_seg_dot_on;
  logic [SEG_COUNT-1:0] dc_mask;
  logic [SEG_COUNT-1:0] dc_level;

  always_comb begin
    dc_mask = '0;
    for (int g = 0; g < DC_GRP_W; g++) begin
      dc_mask[DC_SEG_BASE + g]            = DC_LO_EN; // RULE14
      dc_mask[DC_SEG_BASE + DC_GRP_W + g] = DC_HI_EN; // RULE14
    end
  end

  logic [RAM_IDX_W-1:0] scan_word_ofs;
  logic [NIB_SEL_W-1:0] scan_bit;

  // Four commons share one word: upper index bits pick the word, lower the bit
  always_comb begin
    scan_word_ofs = RAM_IDX_W'(com_index[COM_IDX_W-1:NIB_SEL_W]);
    scan_bit      = com_index[NIB_SEL_W-1:0];
  end

  // Autonomous fetch: all segments of the current common read in parallel
  always_comb begin
    next_seg_dot_on = '0;
    for (int s = 0; s < SEG_COUNT; s++) begin
      next_seg_dot_on[s] =
        display_ram[RAM_IDX_W'(s * WORDS_PER_SEG) + scan_word_ofs][scan_bit]; // RULE6 RULE7
    end
    next_seg_dot_on = next_seg_dot_on & ~dc_mask;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seg_dot_on <= '0;
    end else begin
      seg_dot_on <= display_enabled ? next_seg_dot_on : '0; // RULE8 RULE6
    end
  end

  // ----------------------------------------
  // DC outputs
  // ----------------------------------------
  // DC pins follow the stored words through a register, so a write lands on the pins one clock after the store
  always_comb begin
    dc_level = '0;
    for (int g = 0; g < DC_GRP_W; g++) begin
      dc_level[DC_SEG_BASE + g]            = display_ram[DC_LO_ADDR][g]; // RULE15
      dc_level[DC_SEG_BASE + DC_GRP_W + g] = display_ram[DC_HI_ADDR][g]; // RULE15
    end
  end

  assign seg_dc_mode = dc_mask;

  // Open drain: bit zero pulls the pin low, bit one releases it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seg_dc_oe <= '0;
    end else begin
      seg_dc_oe <= dc_mask & ~dc_level; // RULE16
    end
  end

  logic unused_hold;
  assign unused_hold = hold_mode;

endmodule
`default_nettype wire

/* dv/lcd_drive_monitor.sv */
/* Port checker for lcd_drive.
   Assumes the bind below; parameters follow the instance. */
`timescale 1ns/1ns
`default_nettype none
module lcd_drive_monitor
  import lcd_pkg::*;
#(
  parameter bit DC_LO_EN = 1'b0,  // Low DC group built
  parameter bit DC_HI_EN = 1'b0   // High DC group built
) (
  input wire logic                  clock,                   // Clock
  input wire logic                  sys_rst,                 // Sync reset
  input wire lcd_core_req_t         core_req,                // Core strobes
  input wire logic [NIB_W-1:0]      ram_rdata,               // Read data
  input wire logic                  ram_rvalid,              // Read valid
  input wire logic                  display_enabled,         // Drive on
  input wire logic [CONTRAST_W-1:0] contrast_tap,            // Tap code
  input wire logic                  frame_alternating_clock, // Toggle
  input wire logic [COM_COUNT-1:0]  com_select,              // Common
  input wire logic [SEG_COUNT-1:0]  seg_dot_on,              // Dots
  input wire logic [SEG_COUNT-1:0]  seg_dc_mode,             // DC mask
  input wire logic [SEG_COUNT-1:0]  seg_dc_oe                // DC pull-low
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  localparam logic [39:0] DC_MASK = {{4{DC_HI_EN}}, {4{DC_LO_EN}}, 32'h0};
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_read_req; core_req.ram_re; endsequence
  sequence s_read_ans; ram_rvalid; endsequence

  a_read_answer: assert property (s_read_req |=> s_read_ans)
    else $error("read not answered next cycle");
  a_read_cause: assert property (ram_rvalid |-> $past(core_req.ram_re))
    else $error("read valid without request");
  // Guard on past reset: a one-cycle reset may clear a value unannounced
  a_rdata_hold: assert property (!ram_rvalid && !$past(sys_rst) |-> $stable(ram_rdata))
    else $error("read data moved without read");
  a_on_takes: assert property (core_req.on_cmd |=> display_enabled)
    else $error("on command ignored");
  a_off_takes: assert property (core_req.off_cmd && !core_req.on_cmd |=> !display_enabled)
    else $error("off command ignored");
  a_enable_cause: assert property (!$past(sys_rst) && $changed(display_enabled)
    |-> $past(core_req.on_cmd || core_req.off_cmd))
    else $error("display state changed by itself");
  a_contrast_load: assert property (core_req.contrast_we
    |=> contrast_tap == $past(core_req.wdata[2:0]))
    else $error("contrast code not loaded");
  a_com_single: assert property ($onehot0(com_select))
    else $error("more than one common active");
  a_dark_off: assert property (!display_enabled [*2] |-> com_select == '0)
    else $error("common active while off");
  a_dc_mask: assert property (seg_dc_mode == DC_MASK)
    else $error("wrong DC segment mask");
  a_dc_clean: assert property ((seg_dot_on & seg_dc_mode) == '0
    && (seg_dc_oe & ~seg_dc_mode) == '0)
    else $error("DC and panel segments mixed");
  a_alt_idle: assert property (!$past(sys_rst) && $changed(frame_alternating_clock)
    |-> $past(display_enabled))
    else $error("frame toggle while off");
endmodule

bind lcd_drive lcd_drive_monitor #(.DC_LO_EN(DC_LO_EN), .DC_HI_EN(DC_HI_EN)) i_mon (
  .clock(clock), .sys_rst(sys_rst), .core_req(core_req), .ram_rdata(ram_rdata),
  .ram_rvalid(ram_rvalid), .display_enabled(display_enabled), .contrast_tap(contrast_tap),
  .frame_alternating_clock(frame_alternating_clock), .com_select(com_select),
  .seg_dot_on(seg_dot_on), .seg_dc_mode(seg_dc_mode), .seg_dc_oe(seg_dc_oe));
`default_nettype wire

/* dv/lcd_panel_model.sv */
/* Panel glass model: latches dot states per common, shows DC pin levels.
   Assumes a board pull-up on every open-drain segment pin. */
`timescale 1ns/1ns
`default_nettype none
module lcd_panel_model
  import lcd_pkg::*;
(
  input  wire logic                  clock,      // Clock
  input  wire logic [COM_COUNT-1:0]  com_select, // Active common
  input  wire logic [SEG_COUNT-1:0]  seg_dot_on, // Dot states
  input  wire logic [SEG_COUNT-1:0]  seg_dc_oe,  // Pull-low enables
  output logic [SEG_COUNT-1:0]       pin_level,  // Pin level seen
  output logic [COM_COUNT-1:0][SEG_COUNT-1:0] dots // Last state per dot
);
  // Released pins float high through the pull-up
  assign pin_level = ~seg_dc_oe;
  always_ff @(posedge clock) begin
    for (int c = 0; c < COM_COUNT; c++) begin
      if (com_select[c]) begin
        dots[c] <= seg_dot_on;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/lcd_drive_tb.sv */
/* Self-checking bench for lcd_drive with the panel model.
   Assumes sixteenth duty, low DC group built, high group not. */
`timescale 1ns/1ns
`default_nettype none
module lcd_drive_tb import lcd_pkg::*; ();
  localparam int B_OFF = 4, B_ON = 5, B_CON = 6, B_RE = 7, B_WE = 8, B_HI = 9, B_LO = 10;
  logic          clock = 1'b0;
  logic          sys_rst = 1'b1;
  lcd_core_req_t core_req = '0;
  lcd_div_t      frame_div = LCD_DIV16;
  logic          hold_mode = 1'b1;
  logic [3:0]    ram_rdata;
  logic          ram_rvalid, display_enabled, fac;
  logic [2:0]    contrast_tap;
  logic [15:0]   com_select, prev;
  logic [39:0]   seg_dot_on, seg_dc_mode, seg_dc_oe, pin_level;
  logic [15:0][39:0] dots;
  logic [3:0]    mem [0:159];
  logic [3:0]    exp_q [$];
  logic [3:0]    d;
  logic [7:0]    c;
  logic          a0;
  int            failures = 0;
  int            checks = 0;
  int            k;

  always #20 clock = ~clock;

  lcd_drive #(.DUTY16(1'b1), .DC_LO_EN(1'b1), .DC_HI_EN(1'b0)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .core_req(core_req), .frame_div(frame_div),
    .hold_mode(hold_mode), .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
    .display_enabled(display_enabled), .contrast_tap(contrast_tap),
    .frame_alternating_clock(fac), .com_select(com_select), .seg_dot_on(seg_dot_on),
    .seg_dc_mode(seg_dc_mode), .seg_dc_oe(seg_dc_oe));
  lcd_panel_model i_panel (.clock(clock), .com_select(com_select), .seg_dot_on(seg_dot_on),
    .seg_dc_oe(seg_dc_oe), .pin_level(pin_level), .dots(dots));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic pulse(input logic [10:0] q);
    @(posedge clock);
    core_req <= q;
    @(posedge clock);
    core_req <= '0;
  endtask
  task automatic op(input int b, input logic [3:0] v);
    pulse((11'h1 << b) | {7'h0, v});
  endtask
  function automatic logic mapped(input logic [7:0] p);
    return p <= 8'h4f || (p >= 8'h80 && p <= 8'hcf);
  endfunction
  task automatic point(input logic [7:0] p);
    op(B_LO, p[3:0]);
    op(B_HI, p[7:4]);
  endtask
  task automatic wr(input logic [7:0] p, input logic [3:0] v);
    point(p);
    op(B_WE, v);
    if (mapped(p)) mem[p <= 8'h4f ? p : p - 8'h30] = v;
  endtask
  task automatic rd(input logic [7:0] p);
    point(p);
    exp_q.push_back(mapped(p) ? mem[p <= 8'h4f ? p : p - 8'h30] : 4'h0);
    op(B_RE, 4'h0);
  endtask

  // Read results are matched in order against the noted values
  always @(posedge clock) begin
    if (ram_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(64'h1, 64'h0);
      else check(ram_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    finish_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'he25f));
    foreach (mem[i]) mem[i] = 4'h0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check(display_enabled, 0);
    check(com_select, 0);
    check(contrast_tap, 0);
    for (int i = 0; i < 4; i++) begin
      wr(i[7:0], 4'($urandom));
      wr(8'hcc + i[7:0], 4'($urandom));
    end
    wr(8'h50, 4'hf);
    wr(8'hd0, 4'hf);
    for (int i = 0; i < 4; i++) begin
      rd(i[7:0]);
      rd(8'hcc + i[7:0]);
    end
    rd(8'h50);
    rd(8'hd0);
    rd(8'h80);
    d = 4'($urandom);
    wr(8'h40, d);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(seg_dc_oe[35:32], {~d});
    check(pin_level[35:32], d);
    check(seg_dc_oe[39:36], 0);
    rd(8'h40);
    op(B_CON, 4'hd);
    @(negedge clock);
    check(contrast_tap, 3'h5);
    pulse(11'h030);
    @(negedge clock);
    check(display_enabled, 1);
    op(B_OFF, 4'h0);
    @(negedge clock);
    check(display_enabled, 0);
    op(B_ON, 4'h0);
    // Let the first common show before timing the scan
    repeat (2) @(negedge clock);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        @(posedge clock);
        frame_div <= LCD_DIV32;
      end
      prev = com_select;
      a0 = fac;
      k = 0;
      while (com_select === prev && k < 30000) begin
        @(posedge clock);
        k++;
      end
      repeat (2) @(negedge clock);
      check(64'(k >= 30000), 0);
      check(64'(k > 20000), s);
      check(64'($onehot(com_select)), 1);
      check(fac, {~a0});
      for (int j = 0; j < 16; j++) if (com_select[j]) c = j[7:0];
      check(seg_dot_on[0], mem[c / 4][c % 4]);
      check(seg_dot_on[39], mem[156 + c / 4][c % 4]);
      check(seg_dot_on[35:32], 0);
      @(negedge clock);
      check(dots[c][0], mem[c / 4][c % 4]);
    end
    check(exp_q.size(), 0);
    finish_test;
  end
endmodule
`default_nettype wire
